// ===== rtl/tcs_timer_capture_setup.sv
// The APB slave port is this design's own decision.
`timescale 1ns/10ps
module tcs_timer_capture_setup
	import tcs_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	// Clock and reset
	input  wire logic              ref_clk_i,
	input  wire logic              reset_i,
	// APB slave
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [ADDR_W-1:0] paddr_i,
	input  wire logic [31:0]       pwdata_i,
	input  wire logic [3:0]        pstrb_i,
	output logic [31:0]            prdata_o,
	output logic                   pready_o,
	output logic                   pslverr_o,
	// External pins
	input  wire logic              shared_ext_clock_pin_i,
	input  wire logic              timer_three_ext_clock_pin_i,
	input  wire logic              first_capture_pin_i,
	input  wire logic              second_capture_pin_i,
	// Configuration and timer controls
	output tcs_setup_s             setup_o,
	output tcs_tick_s              tick_o,
	output logic                   timer_pair_join_o,
	output logic                   instr_tick_o,
	output logic                   first_capture_o,
	output logic                   second_capture_o
);

	// Access states of the APB slave
	typedef enum logic [2:0] {
		TCS_IDLE   = 3'b001,
		TCS_ACCESS = 3'b010,
		TCS_DONE   = 3'b100
	} tcs_bus_e;

	tcs_bus_e          bus_q, bus_d;
	logic [7:0]        setup_q, setup_d;
	tcs_setup_s        live_q, live_d;
	logic [31:0]       rdata_q, rdata_d;
	logic              ready_q, ready_d;
	logic              err_q, err_d;
	logic [1:0]        div_q, div_d;
	logic              instr_q, instr_d;
	logic [1:0]        shs_q, shs_d;
	logic [1:0]        t3s_q, t3s_d;
	logic              shp_q, shp_d;
	logic              t3p_q, t3p_d;
	logic              shf_q, shf_d;
	logic              t3f_q, t3f_d;
	tcs_tick_s         tick_q, tick_d;
	logic              join_q, join_d;
	logic [1:0]        cps_q, cps_d;
	logic [1:0]        cps2_q, cps2_d;
	logic              cap1_w, cap2_w;
	logic              ext_sh_w, ext_t3_w;

	// APB slave: one wait state, access completes with pready high for one cycle
	always_comb begin
		logic hit;
		hit     = (paddr_i == ADDR_W'(TCS_SETUP_ADDR));
		bus_d   = bus_q;
		setup_d = setup_q;
		rdata_d = rdata_q;
		ready_d = 1'b0;
		err_d   = 1'b0;
		case (bus_q)
			TCS_IDLE: begin
				if (psel_i && !penable_i) begin
					bus_d = TCS_ACCESS;
				end
			end
			TCS_ACCESS: begin
				ready_d = 1'b1;
				bus_d   = TCS_DONE;
				rdata_d = 32'h0000_0000;
				if (!hit) begin
					err_d = 1'b1;
				end else if (!pwrite_i) begin
					rdata_d = {24'h00_0000, setup_q};
				end
			end
			default: begin
				bus_d = TCS_IDLE;
				// write lands at the edge where the master samples pready
				if (psel_i && penable_i && pwrite_i && hit && pstrb_i[0]) begin
					setup_d = pwdata_i[7:0];
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			bus_q   <= TCS_IDLE;
			setup_q <= TCS_SETUP_RESET;
			rdata_q <= 32'h0000_0000;
			ready_q <= 1'b0;
			err_q   <= 1'b0;
		end else begin
			bus_q   <= bus_d;
			setup_q <= setup_d;
			rdata_q <= rdata_d;
			ready_q <= ready_d;
			err_q   <= err_d;
		end
	end

	// core clock over four, an enable pulse rather than a second clock
	always_comb begin
		div_d   = div_q + 2'h1;
		instr_d = (div_q == 2'(TCS_INSTR_DIV - 1));
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			div_q   <= 2'h0;
			instr_q <= 1'b0;
		end else begin
			div_q   <= div_d;
			instr_q <= instr_d;
		end
	end

	// two-stage synchroniser, edge seen on second stage only
	// Reset to the pull-up level so the first samples after reset show no false fall
	always_comb begin
		shs_d = {shs_q[0], shared_ext_clock_pin_i};
		t3s_d = {t3s_q[0], timer_three_ext_clock_pin_i};
		shp_d = shs_q[1];
		t3p_d = t3s_q[1];
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			shs_q <= 2'h3;
			t3s_q <= 2'h3;
			shp_q <= 1'b1;
			t3p_q <= 1'b1;
		end else begin
			shs_q <= shs_d;
			t3s_q <= t3s_d;
			shp_q <= shp_d;
			t3p_q <= t3p_d;
		end
	end

	// Falling edges held until the next boundary; an edge in the boundary cycle is used at once
	always_comb begin
		ext_sh_w = shf_q | (shp_q & ~shs_q[1]);
		ext_t3_w = t3f_q | (t3p_q & ~t3s_q[1]);
		shf_d    = instr_q ? 1'b0 : ext_sh_w;
		t3f_d    = instr_q ? 1'b0 : ext_t3_w;
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			shf_q <= 1'b0;
			t3f_q <= 1'b0;
		end else begin
			shf_q <= shf_d;
			t3f_q <= t3f_d;
		end
	end

	// new setting adopted only at instruction boundary
	// Switching there keeps a timer from seeing a split or doubled advance
	always_comb begin
		live_d = instr_q ? tcs_setup_s'(setup_q) : live_q;
		join_d = live_q.timer_pair_join;
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			live_q <= tcs_setup_s'(TCS_SETUP_RESET);
			join_q <= 1'b0;
		end else begin
			live_q <= live_d;
			join_q <= join_d;
		end
	end

	// Advance pulses, only in the cycle after an instruction boundary
	always_comb begin
		tick_d = '0;
		if (instr_q) begin
			tick_d.timer_one   = live_q.timer_one_source ? ext_sh_w : 1'b1;
			if (live_q.timer_pair_join) begin
				tick_d.timer_two = tick_d.timer_one;
			end else begin
				tick_d.timer_two = live_q.timer_two_source ? ext_sh_w : 1'b1;
			end
			tick_d.timer_three = live_q.timer_three_source ? ext_t3_w : 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			tick_q <= '0;
		end else begin
			tick_q <= tick_d;
		end
	end

	// Capture pins through two flops; reset at the idle high level to avoid a false rise
	always_comb begin
		cps_d  = {cps_q[0], first_capture_pin_i};
		cps2_d = {cps2_q[0], second_capture_pin_i};
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			cps_q  <= 2'h3;
			cps2_q <= 2'h3;
		end else begin
			cps_q  <= cps_d;
			cps2_q <= cps2_d;
		end
	end

	tcs_capture_trigger #(
		.PRE_W (4)
	) u_first_trig (
		.ref_clk_i (ref_clk_i),
		.reset_i   (reset_i),
		.mode_i    (live_q.first_capture_edge_mode),
		.pin_i     (cps_q[1]),
		.trig_o    (cap1_w)
	);

	tcs_capture_trigger #(
		.PRE_W (4)
	) u_second_trig (
		.ref_clk_i (ref_clk_i),
		.reset_i   (reset_i),
		.mode_i    (live_q.second_capture_edge_mode),
		.pin_i     (cps2_q[1]),
		.trig_o    (cap2_w)
	);

	// Outputs come straight from flops (trigger outputs are flops inside the leaf)
	assign prdata_o          = rdata_q;
	assign pready_o          = ready_q;
	assign pslverr_o         = err_q;
	assign setup_o           = live_q;
	assign tick_o            = tick_q;
	assign timer_pair_join_o = join_q;
	assign instr_tick_o      = instr_q;
	assign first_capture_o   = cap1_w;
	assign second_capture_o  = cap2_w;

endmodule : tcs_timer_capture_setup

// ===== rtl/tcs_pkg.sv
package tcs_pkg;

	// Register map (byte address on APB)
	localparam logic [11:0] TCS_SETUP_ADDR   = 12'h016 << 2;
	localparam logic [11:0] TCS_SETUP_IDX    = 12'h016;
	localparam logic [7:0]  TCS_SETUP_RESET  = 8'h00;

	// Field positions inside timer_capture_setup
	localparam int TCS_SECOND_EDGE_LSB = 6;
	localparam int TCS_FIRST_EDGE_LSB  = 4;
	localparam int TCS_JOIN_BIT        = 3;
	localparam int TCS_T3_SRC_BIT      = 2;
	localparam int TCS_T2_SRC_BIT      = 1;
	localparam int TCS_T1_SRC_BIT      = 0;

	// Core clock cycles per instruction cycle
	localparam int TCS_INSTR_DIV = 4;

	// Capture edge modes
	localparam logic [1:0] TCS_EDGE_FALL  = 2'h0;
	localparam logic [1:0] TCS_EDGE_RISE  = 2'h1;
	localparam logic [1:0] TCS_EDGE_RISE4 = 2'h2;
	localparam logic [1:0] TCS_EDGE_RISE16 = 2'h3;

	// Configuration fields as driven to the timer logic
	typedef struct packed {
		logic [1:0] second_capture_edge_mode;
		logic [1:0] first_capture_edge_mode;
		logic       timer_pair_join;
		logic       timer_three_source;
		logic       timer_two_source;
		logic       timer_one_source;
	} tcs_setup_s;

	// Per-timer advance pulses
	typedef struct packed {
		logic timer_three;
		logic timer_two;
		logic timer_one;
	} tcs_tick_s;

endpackage : tcs_pkg

// ===== rtl/tcs_capture_trigger.sv
`timescale 1ns/10ps
// Edge qualifier for one capture channel, prescaled rising edges
module tcs_capture_trigger
	import tcs_pkg::*;
#(
	parameter int PRE_W = 4
) (
	// Clock and reset
	input  wire logic       ref_clk_i,
	input  wire logic       reset_i,
	// Mode and sampled pin
	input  wire logic [1:0] mode_i,
	input  wire logic       pin_i,
	// Trigger pulse
	output logic            trig_o
);

	logic             prev_q, prev_d;
	logic [PRE_W-1:0] cnt_q, cnt_d;
	logic [1:0]       mode_q, mode_d;
	logic             trig_q, trig_d;

	// Edge detect and prescale; a mode change clears the prescaler so no stale count fires
	always_comb begin
		logic rise;
		logic fall;
		rise   = pin_i & ~prev_q;
		fall   = ~pin_i & prev_q;
		prev_d = pin_i;
		mode_d = mode_i;
		cnt_d  = cnt_q;
		trig_d = 1'b0;
		if (mode_i != mode_q) begin
			cnt_d = '0;
		end else begin
			case (mode_q)
				TCS_EDGE_FALL: trig_d = fall;
				TCS_EDGE_RISE: trig_d = rise;
				TCS_EDGE_RISE4: begin
					if (rise) begin
						cnt_d  = (cnt_q[1:0] == 2'h3) ? '0 : cnt_q + 1'b1;
						trig_d = (cnt_q[1:0] == 2'h3);
					end
				end
				default: begin
					if (rise) begin
						cnt_d  = cnt_q + 1'b1;
						trig_d = (cnt_q == '1);
					end
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			prev_q <= 1'b1; // Idle high pin, no edge right after reset
			cnt_q  <= '0;
			mode_q <= TCS_EDGE_FALL;
			trig_q <= 1'b0;
		end else begin
			prev_q <= prev_d;
			cnt_q  <= cnt_d;
			mode_q <= mode_d;
			trig_q <= trig_d;
		end
	end

	assign trig_o = trig_q;

endmodule : tcs_capture_trigger

// ===== tb/tcs_asserts.sv
`timescale 1ns/10ps
// Watches bus answers, tick cadence and setup hand-off
module tcs_asserts
	import tcs_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	// Clock, reset and bus
	input wire logic              ref_clk_i,
	input wire logic              reset_i,
	input wire logic              psel_i,
	input wire logic              penable_i,
	input wire logic [ADDR_W-1:0] paddr_i,
	input wire logic [31:0]       prdata_o,
	input wire logic              pready_o,
	input wire logic              pslverr_o,
	// Timer controls
	input wire tcs_setup_s        setup_o,
	input wire tcs_tick_s         tick_o,
	input wire logic              timer_pair_join_o,
	input wire logic              instr_tick_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	sequence bus_setup; psel_i && !penable_i; endsequence
	sequence no_tick3; !instr_tick_o [*3]; endsequence

	ready_wait_a: assert property (bus_setup |-> ##2 pready_o) else $error("Late ready");
	ready_pulse_a: assert property (pready_o |=> !pready_o) else $error("Ready too long");
	unmapped_err_a: assert property (pready_o && paddr_i != TCS_SETUP_ADDR |-> pslverr_o && prdata_o == 32'h0)
		else $error("Unmapped access accepted");
	mapped_ok_a: assert property (pready_o && paddr_i == TCS_SETUP_ADDR |-> !pslverr_o && prdata_o[31:8] == 24'h0)
		else $error("Mapped access refused");
	instr_period_a: assert property (instr_tick_o |=> no_tick3 ##1 instr_tick_o) else $error("Bad tick period");
	tick_boundary_a: assert property (tick_o != 3'h0 |-> $past(instr_tick_o)) else $error("Stray tick");
	join_lag_a: assert property (timer_pair_join_o == $past(setup_o.timer_pair_join)) else $error("Join lag");
	join_same_a: assert property (timer_pair_join_o && setup_o.timer_pair_join |-> tick_o.timer_two == tick_o.timer_one)
		else $error("Joined ticks differ");
	setup_hold_a: assert property ($changed(setup_o) |-> $past(instr_tick_o)) else $error("Setup off boundary");
	int_tick_a: assert property ($past(instr_tick_o) && !$past(setup_o.timer_three_source) |-> tick_o.timer_three)
		else $error("Missing internal tick");
endmodule : tcs_asserts

bind tcs_timer_capture_setup tcs_asserts #(.ADDR_W(ADDR_W)) u_asserts (
	.ref_clk_i         (ref_clk_i),
	.reset_i           (reset_i),
	.psel_i            (psel_i),
	.penable_i         (penable_i),
	.paddr_i           (paddr_i),
	.prdata_o          (prdata_o),
	.pready_o          (pready_o),
	.pslverr_o         (pslverr_o),
	.setup_o           (setup_o),
	.tick_o            (tick_o),
	.timer_pair_join_o (timer_pair_join_o),
	.instr_tick_o      (instr_tick_o)
);

// ===== tb/tcs_pins_model.sv
`timescale 1ns/10ps
// External pins: {second cap, first cap, timer three clk, shared clk}
module tcs_pins_model (
	// Clock and control
	input  wire logic       ref_clk_i,
	input  wire logic [3:0] run_i,
	// Pins
	output logic [3:0]      pin_o
);
	localparam int HALF [4] = '{8, 4, 2, 2};
	int cnt [4];
	// Stopped pins rest at the pull-up level, so no false edge appears
	always @(posedge ref_clk_i) begin
		for (int i = 0; i < 4; i++) begin
			if (!run_i[i]) begin
				pin_o[i] <= 1'b1;
				cnt[i] <= 0;
			end else if (cnt[i] == HALF[i] - 1) begin
				pin_o[i] <= ~pin_o[i];
				cnt[i] <= 0;
			end else begin
				cnt[i] <= cnt[i] + 1;
			end
		end
	end
endmodule : tcs_pins_model

// ===== tb/tcs_timer_capture_setup_tb_top.sv
`timescale 1ns/10ps
// Bench for the timer and capture setup register
module tcs_timer_capture_setup_tb_top
	import tcs_pkg::*;
;
	logic        clk, rst, psel, pen, pwr, rdy, err, jn, itk, c1, c2, gerr;
	logic [11:0] addr;
	logic [31:0] wdata, rdata, got;
	logic [3:0]  strb, run, pins;
	tcs_setup_s  setup;
	tcs_tick_s   tick;
	int          bad_count, checks_done, cnt [5];

	// Far side and device
	tcs_pins_model u_pins (.ref_clk_i(clk), .run_i(run), .pin_o(pins));
	tcs_timer_capture_setup u_dut (.ref_clk_i(clk), .reset_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
		.paddr_i(addr), .pwdata_i(wdata), .pstrb_i(strb), .prdata_o(rdata), .pready_o(rdy), .pslverr_o(err),
		.shared_ext_clock_pin_i(pins[0]), .timer_three_ext_clock_pin_i(pins[1]), .first_capture_pin_i(pins[2]),
		.second_capture_pin_i(pins[3]), .setup_o(setup), .tick_o(tick), .timer_pair_join_o(jn),
		.instr_tick_o(itk), .first_capture_o(c1), .second_capture_o(c2));

	// 25 MHz clock
	initial begin
		clk = 0;
		forever #20 clk = ~clk;
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("Error %0t: got %h want %h", $time, g, e);
		end
	endtask : chk

	// Counts may slip by a boundary edge or two
	task automatic near(input int g, input int e);
		chk(32'(g >= e - 2 && g <= e + 2), 32'h1);
	endtask : near

	task end_of_test;
		$display("Checks %0d errors %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test

	// One bus transfer, held until ready is sampled
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		int i;
		@(posedge clk);
		{psel, pen, pwr, addr, wdata, strb} <= {1'b1, 1'b0, w, a, d, s};
		@(posedge clk);
		pen <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (rdy === 1'b1) break;
		end
		if (i == 20) begin
			bad_count++;
			end_of_test();
		end
		got = rdata;
		gerr = err;
		{psel, pen} <= 2'b00;
	endtask : apb

	task automatic set_win(input logic [7:0] v);
		apb(1, TCS_SETUP_ADDR, {24'h0, v}, 4'hf);
		repeat (8) @(posedge clk);
		cnt = '{default: 0};
		repeat (400) begin
			@(posedge clk);
			cnt[0] += tick.timer_one;
			cnt[1] += tick.timer_two;
			cnt[2] += tick.timer_three;
			cnt[3] += c1;
			cnt[4] += c2;
		end
	endtask : set_win

	task automatic s_regs;
		logic [7:0] v [3] = '{8'ha5, 8'h5a, 8'hff};
		apb(0, TCS_SETUP_ADDR, 0, 4'hf);
		chk(got, 32'h0);
		foreach (v[k]) begin
			apb(1, TCS_SETUP_ADDR, {24'hffffff, v[k]}, 4'hf);
			apb(0, TCS_SETUP_ADDR, 0, 4'hf);
			chk(got, {24'h0, v[k]});
			repeat (6) @(posedge clk);
			chk(32'(setup), 32'(v[k]));
		end
		apb(1, TCS_SETUP_ADDR + 12'h4, 0, 4'hf);
		chk(32'(gerr), 32'h1);
		apb(1, TCS_SETUP_ADDR, 0, 4'h0);
		apb(0, TCS_SETUP_ADDR, 0, 4'hf);
		chk(got, 32'hff);
	endtask : s_regs

	// Shared pin falls every 16 cycles, timer three pin every 8
	task automatic s_src;
		int t [4][4] = '{'{0, 100, 100, 100}, '{7, 25, 25, 50}, '{2, 100, 25, 100}, '{9, 25, 25, 100}};
		foreach (t[k]) begin
			set_win(8'(t[k][0]));
			near(cnt[0], t[k][1]);
			near(cnt[1], t[k][2]);
			near(cnt[2], t[k][3]);
			chk(32'(jn), 32'(t[k][0] == 9));
		end
	endtask : s_src

	// Capture pins rise every 4 cycles
	task automatic s_cap;
		int e [4] = '{100, 100, 25, 6};
		for (int m = 0; m < 4; m++) begin
			set_win({m[1:0], m[1:0], 4'h0});
			near(cnt[3], e[m]);
			near(cnt[4], e[m]);
		end
	endtask : s_cap

	// Main sequence, ending with a mid-run reset
	initial begin
		{rst, psel, pen, pwr, addr, wdata, strb, run} = '0;
		rst = 1;
		repeat (16) @(posedge clk);
		rst <= 0;
		run <= 4'hf;
		s_regs();
		s_src();
		s_cap();
		rst <= 1;
		repeat (16) @(posedge clk);
		rst <= 0;
		apb(0, TCS_SETUP_ADDR, 0, 4'hf);
		chk(got, 32'h0);
		end_of_test();
	end
endmodule : tcs_timer_capture_setup_tb_top
